// File: hdl/tc_pkg.sv
// Constants and types for the timer counter core
`default_nettype none
package tc_pkg;
// Functional notes
// - Counter advances on input events or on prescaled clock ticks.
// - Width selectable 8, 16 or 32 bits; 16-bit after reset.
// - Control A (except keep-run, enable, soft reset) and event action locked while enabled.
// - Locked fields load with a write setting enable, not one clearing it.
// - Soft reset restores all registers except debug hold, timer disabled.
// - Prescaler counts to selected division, 1 to 1024.
// - Sync select: prescaler cleared or kept on wrap; wrap on clock or tick.
// - Counted events bypass the prescaler.
// - Top-limit register sets the top only in 8-bit width; it is readable and writable in every width.
// - Odd follower instance reports role; its register writes are ignored.
// - Up wraps to zero after top, down reloads top; single-run stops.
// - Direction set selects down, direction clear selects up.
// - Wrap sets wrap flag; emits event when wrap event enabled.
// - Counter readable, writable, zero at start unless written or reloaded.
// - Stop freezes count, clears waveforms, halts, shows stop status.
// - Retrigger wraps a running counter; a stopped one resumes.
// - Retrigger action: enable waits, each event starts or restarts.
// - Count action: each event steps counter by direction.
// - Start action: enable waits for event or retrigger; later events ignored.
// - Match sets channel flag on a count step (tick or counted event); event when enabled.
// - Four waveform modes; normal modes top is limit or maximum.
// - Normal frequency: output toggles on match, flag set.
// - Match frequency: channel zero is top, output zero toggles on wrap.
   localparam int CH_N = 2;
   localparam int PSC_W = 10;
   localparam logic [7:0] A_CONTROL_A = 8'h00, A_BCLR = 8'h04, A_BSET = 8'h08;
   localparam logic [7:0] A_CONTROL_C = 8'h0C, A_EVCTRL = 8'h10, A_FLAGS = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1C, A_COUNT = 8'h20, A_PER = 8'h24;
   localparam logic [7:0] A_CC0 = 8'h28, A_CC1 = 8'h2C, A_DEBUG = 8'h30;
   localparam int B_SOFT_RESET_BIT = 0, B_EN = 1, B_MODE = 2, B_WAVE = 5;
   localparam int B_PSC = 8, B_KEEP = 11, B_SYNC = 12;
   localparam int B_DIR = 0, B_ONE = 2, B_CMD = 6;
   localparam int B_INV = 0, B_CPT = 4, B_EVA = 0, B_WRAP_EVENT_ENABLE = 8, B_MCEO = 12;
   localparam int B_WRAPF = 0, B_MATCHF = 4, B_STOP = 3, B_FOLLOW = 4;
   localparam logic [31:0] MAX8 = 32'h000000FF, MAX16 = 32'h0000FFFF;
   localparam logic [31:0] MAX32 = 32'hFFFFFFFF, ZERO32 = 32'h00000000;
   localparam logic [7:0] PER_RST = 8'hFF;
   typedef enum logic [1:0] {width_16bit_mode, width_8bit_mode, width_32bit_mode} tc_width_t;
   typedef enum logic [1:0] {normal_frequency_mode, match_frequency_mode,
      normal_pulse_width_mode, match_pulse_width_mode} tc_wave_t;
   typedef enum logic [1:0] {ev_off, ev_retrigger, ev_count, ev_start} tc_input_event_action_t;
   typedef enum logic [1:0] {cmd_none, cmd_retrigger, cmd_stop} tc_cmd_t;
   typedef enum logic [1:0] {sync_gclk, sync_prescaled, sync_resync} tc_sync_t;
   typedef enum logic {run_stopped, run_counting} tc_run_t;
   function automatic logic [PSC_W-1:0] tc_div_last(input logic [2:0] sel);
      case (sel)
         3'h1: tc_div_last = 10'h001;
         3'h2: tc_div_last = 10'h003;
         3'h3: tc_div_last = 10'h007;
         3'h4: tc_div_last = 10'h00F;
         3'h5: tc_div_last = 10'h03F;
         3'h6: tc_div_last = 10'h0FF;
         3'h7: tc_div_last = 10'h3FF;
         default: tc_div_last = 10'h000;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: hdl/tc_timer_counter_core.sv
// Timer counter core with register port, prescaler and waveform channels
`default_nettype none
module tc_timer_counter_core #(
   parameter bit ODD_INSTANCE = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        event_in,
   input  wire logic        pair_master_32,
   output logic             wrap_event,
   output logic      [1:0]  match_event,
   output logic      [1:0]  waveform_output
);
   localparam int CH = tc_pkg::CH_N;

   // Register state
   logic enable_r;
   logic keep_run_r;
   tc_pkg::tc_width_t mode_r;
   tc_pkg::tc_wave_t wave_r;
   logic [2:0] psc_sel_r;
   tc_pkg::tc_sync_t sync_r;
   logic dir_r;
   logic single_r;
   logic [1:0] output_invert_enables_r;
   logic [1:0] capen_r;
   tc_pkg::tc_input_event_action_t input_event_action_r;
   logic wrap_event_enable_r;
   logic [1:0] mceo_r;
   logic wrap_flag_r;
   logic [1:0] mflag_r;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic [7:0] per_r;
   logic [31:0] cc_r [CH];
   logic debug_r;
   tc_pkg::tc_run_t run_r;
   tc_pkg::tc_run_t run_nxt;
   logic [tc_pkg::PSC_W-1:0] psc_r;
   logic [tc_pkg::PSC_W-1:0] psc_nxt;
   logic [31:0] rdata_r;
   logic wrap_ev_r;
   logic [1:0] mev_r;
   logic [1:0] pin_r;

   // Decode
   wire follower;
   wire wr_ok;
   wire wr_control_a;
   wire wr_bclr;
   wire wr_bset;
   wire wr_control_c;
   wire wr_evctrl;
   wire wr_flags;
   wire wr_count;
   wire wr_per;
   wire wr_debug;
   wire [1:0] wr_cc;
   wire soft_reset_bit;
   wire clr;
   wire prot_ok;
   wire en_rise;
   wire dis_wr;
   wire [1:0] cmd;
   wire stop_cmd;
   wire retrig_cmd;
   wire running;

   // A follower in a 32-bit pair only reflects its own role
   assign follower = ODD_INSTANCE && pair_master_32;
   assign wr_ok = reg_wr && !follower;
   assign wr_control_a = wr_ok && (reg_addr == tc_pkg::A_CONTROL_A);
   assign wr_bclr = wr_ok && (reg_addr == tc_pkg::A_BCLR);
   assign wr_bset = wr_ok && (reg_addr == tc_pkg::A_BSET);
   assign wr_control_c = wr_ok && (reg_addr == tc_pkg::A_CONTROL_C);
   assign wr_evctrl = wr_ok && (reg_addr == tc_pkg::A_EVCTRL);
   assign wr_flags = wr_ok && (reg_addr == tc_pkg::A_FLAGS);
   assign wr_count = wr_ok && (reg_addr == tc_pkg::A_COUNT);
   assign wr_per = wr_ok && (reg_addr == tc_pkg::A_PER);
   assign wr_debug = wr_ok && (reg_addr == tc_pkg::A_DEBUG);
   assign wr_cc[0] = wr_ok && (reg_addr == tc_pkg::A_CC0);
   assign wr_cc[1] = wr_ok && (reg_addr == tc_pkg::A_CC1);
   assign soft_reset_bit = wr_control_a && reg_wdata[tc_pkg::B_SOFT_RESET_BIT];
   assign clr = rst || soft_reset_bit;
   // Locked fields only load while disabled, which covers the enabling write
   assign prot_ok = !enable_r;
   assign en_rise = wr_control_a && !soft_reset_bit && !enable_r && reg_wdata[tc_pkg::B_EN];
   assign dis_wr = wr_control_a && !reg_wdata[tc_pkg::B_EN];
   assign cmd = reg_wdata[tc_pkg::B_CMD +: 2];
   assign stop_cmd = wr_bset && enable_r && (cmd == tc_pkg::cmd_stop);
   assign retrig_cmd = wr_bset && enable_r && (cmd == tc_pkg::cmd_retrigger);
   assign running = (run_r == tc_pkg::run_counting);

   // Control A, soft reset wins over the fields
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         enable_r <= 1'b0;
         keep_run_r <= 1'b0;
         mode_r <= tc_pkg::width_16bit_mode;
         wave_r <= tc_pkg::normal_frequency_mode;
         psc_sel_r <= 3'h0;
         sync_r <= tc_pkg::sync_gclk;
      end else if (wr_control_a) begin
         enable_r <= reg_wdata[tc_pkg::B_EN];
         keep_run_r <= reg_wdata[tc_pkg::B_KEEP];
         if (prot_ok) begin
            mode_r <= tc_pkg::tc_width_t'(reg_wdata[tc_pkg::B_MODE +: 2]);
            wave_r <= tc_pkg::tc_wave_t'(reg_wdata[tc_pkg::B_WAVE +: 2]);
            psc_sel_r <= reg_wdata[tc_pkg::B_PSC +: 3];
            sync_r <= tc_pkg::tc_sync_t'(reg_wdata[tc_pkg::B_SYNC +: 2]);
         end
      end
   end

   // Control B through set and clear aliases
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         dir_r <= 1'b0;
         single_r <= 1'b0;
      end else if (wr_bset) begin
         dir_r <= dir_r | reg_wdata[tc_pkg::B_DIR];
         single_r <= single_r | reg_wdata[tc_pkg::B_ONE];
      end else if (wr_bclr) begin
         dir_r <= dir_r & ~reg_wdata[tc_pkg::B_DIR];
         single_r <= single_r & ~reg_wdata[tc_pkg::B_ONE];
      end
   end

   // Control C and event control
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         output_invert_enables_r <= 2'h0;
         capen_r <= 2'h0;
         input_event_action_r <= tc_pkg::ev_off;
         wrap_event_enable_r <= 1'b0;
         mceo_r <= 2'h0;
      end else begin
         if (wr_control_c) begin
            output_invert_enables_r <= reg_wdata[tc_pkg::B_INV +: 2];
            capen_r <= reg_wdata[tc_pkg::B_CPT +: 2];
         end
         if (wr_evctrl) begin
            if (prot_ok) begin
               input_event_action_r <= tc_pkg::tc_input_event_action_t'(reg_wdata[tc_pkg::B_EVA +: 2]);
            end
            wrap_event_enable_r <= reg_wdata[tc_pkg::B_WRAP_EVENT_ENABLE];
            mceo_r <= reg_wdata[tc_pkg::B_MCEO +: 2];
         end
      end
   end

   // Debug hold survives soft reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         debug_r <= 1'b0;
      end else if (wr_debug) begin
         debug_r <= reg_wdata[0];
      end
   end

   // Top value and width
   wire mode8;
   wire mode32;
   wire match_top;
   wire [31:0] max_val;
   wire [31:0] top_val;
   wire [31:0] cnt_inc;
   wire [31:0] cnt_dec;
   assign mode8 = (mode_r == tc_pkg::width_8bit_mode);
   assign mode32 = (mode_r == tc_pkg::width_32bit_mode);
   assign max_val = mode8 ? tc_pkg::MAX8 : (mode32 ? tc_pkg::MAX32 : tc_pkg::MAX16);
   assign match_top = (wave_r == tc_pkg::match_frequency_mode) ||
                      (wave_r == tc_pkg::match_pulse_width_mode);
   // Only 8-bit width uses the top-limit register
   assign top_val = match_top ? (cc_r[0] & max_val) :
                    (mode8 ? {24'h000000, per_r} : max_val);
   assign cnt_inc = (count_r + 32'h00000001) & max_val;
   assign cnt_dec = (count_r - 32'h00000001) & max_val;

   // Prescaler and stepping
   wire ev_cnt;
   wire tick;
   wire step;
   wire at_limit;
   wire fast_wrap;
   wire wrap_go;
   wire retrig;
   wire start_ev;
   assign ev_cnt = (input_event_action_r == tc_pkg::ev_count);
   assign tick = (psc_r == tc_pkg::tc_div_last(psc_sel_r));
   // Counted events never see the prescaler
   assign step = running && (ev_cnt ? event_in : tick);
   assign at_limit = dir_r ? (count_r == tc_pkg::ZERO32) : (count_r == top_val);
   // Clock-synchronous wrap does not wait for the next prescaled tick
   assign fast_wrap = (sync_r == tc_pkg::sync_gclk) && !ev_cnt;
   assign wrap_go = running && at_limit && (fast_wrap || step);
   assign retrig = retrig_cmd ||
                   (enable_r && event_in && (input_event_action_r == tc_pkg::ev_retrigger));
   assign start_ev = enable_r && event_in && !running &&
                     (input_event_action_r == tc_pkg::ev_start);

   always_comb begin
      psc_nxt = psc_r + 10'h001;
      if (!running || tick) begin
         psc_nxt = 10'h000;
      end else if (wrap_go && (sync_r == tc_pkg::sync_resync)) begin
         psc_nxt = 10'h000;
      end
   end

   always_comb begin
      count_nxt = count_r;
      if (wrap_go) begin
         count_nxt = dir_r ? top_val : tc_pkg::ZERO32;
      end else if (step) begin
         count_nxt = dir_r ? cnt_dec : cnt_inc;
      end
      if (retrig && running) begin
         count_nxt = dir_r ? top_val : tc_pkg::ZERO32;
      end
      if (stop_cmd) begin
         count_nxt = count_r;
      end
      if (wr_count) begin
         count_nxt = reg_wdata & max_val;
      end
   end

   always_comb begin
      run_nxt = run_r;
      if (wrap_go && single_r) begin
         run_nxt = tc_pkg::run_stopped;
      end
      if (retrig || start_ev) begin
         run_nxt = tc_pkg::run_counting;
      end
      if (stop_cmd || dis_wr) begin
         run_nxt = tc_pkg::run_stopped;
      end
      if (en_rise) begin
         case (input_event_action_r)
            tc_pkg::ev_retrigger: run_nxt = tc_pkg::run_stopped;
            tc_pkg::ev_start: run_nxt = tc_pkg::run_stopped;
            default: run_nxt = tc_pkg::run_counting;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clr) begin
         count_r <= tc_pkg::ZERO32;
         run_r <= tc_pkg::run_stopped;
         psc_r <= 10'h000;
      end else begin
         count_r <= count_nxt;
         run_r <= run_nxt;
         psc_r <= psc_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clr) begin
         per_r <= tc_pkg::PER_RST;
      end else if (wr_per) begin
         per_r <= reg_wdata[7:0];
      end
   end

   // Wrap flag: a set in the clearing cycle wins
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         wrap_flag_r <= 1'b0;
         wrap_ev_r <= 1'b0;
      end else begin
         wrap_flag_r <= wrap_go || (wrap_flag_r && !(wr_flags && reg_wdata[tc_pkg::B_WRAPF]));
         wrap_ev_r <= wrap_go && wrap_event_enable_r;
      end
   end

   // Compare channels
   wire [1:0] match_set;
   logic [1:0] wv_nxt;
   logic [1:0] wv_r;
   genvar gi;
   generate
      for (gi = 0; gi < CH; gi++) begin : g_ch
         wire hit;
         assign hit = (count_r == (cc_r[gi] & max_val));
         assign match_set[gi] = hit && step;
         always_comb begin
            wv_nxt[gi] = wv_r[gi];
            case (wave_r)
               tc_pkg::normal_frequency_mode: begin
                  if (match_set[gi]) wv_nxt[gi] = !wv_r[gi];
               end
               tc_pkg::match_frequency_mode: begin
                  if (gi == 0) begin
                     if (wrap_go) wv_nxt[gi] = !wv_r[gi];
                  end else if (match_set[gi]) begin
                     wv_nxt[gi] = !wv_r[gi];
                  end
               end
               default: begin
                  if (wrap_go) wv_nxt[gi] = !dir_r;
                  else if (match_set[gi]) wv_nxt[gi] = dir_r;
               end
            endcase
            if (stop_cmd || !running) wv_nxt[gi] = 1'b0;
         end
         always_ff @(posedge sys_clk) begin
            if (clr) begin
               cc_r[gi] <= tc_pkg::ZERO32;
               wv_r[gi] <= 1'b0;
               pin_r[gi] <= 1'b0;
               mflag_r[gi] <= 1'b0;
               mev_r[gi] <= 1'b0;
            end else begin
               if (wr_cc[gi]) cc_r[gi] <= reg_wdata;
               wv_r[gi] <= wv_nxt[gi];
               pin_r[gi] <= wv_nxt[gi] ^ output_invert_enables_r[gi];
               mflag_r[gi] <= match_set[gi] ||
                  (mflag_r[gi] && !(wr_flags && reg_wdata[tc_pkg::B_MATCHF + gi]));
               mev_r[gi] <= match_set[gi] && mceo_r[gi];
            end
         end
      end
   endgenerate

   // Read path, unmapped offsets read zero
   wire [31:0] rd_mux;
   wire [31:0] control_a_v;
   wire [31:0] ctrlb_v;
   wire [31:0] flags_v;
   wire [31:0] stat_v;
   assign control_a_v = {18'h00000, sync_r, keep_run_r, psc_sel_r, 1'b0, wave_r,
                     1'b0, mode_r, enable_r, 1'b0};
   assign ctrlb_v = {29'h00000000, single_r, 1'b0, dir_r};
   assign flags_v = {26'h0000000, mflag_r, 3'h0, wrap_flag_r};
   assign stat_v = {27'h0000000, follower, !running, 3'h0};
   assign rd_mux =
      (reg_addr == tc_pkg::A_CONTROL_A) ? control_a_v :
      (reg_addr == tc_pkg::A_BCLR) ? ctrlb_v :
      (reg_addr == tc_pkg::A_BSET) ? ctrlb_v :
      (reg_addr == tc_pkg::A_CONTROL_C) ? {26'h0000000, capen_r, 2'h0, output_invert_enables_r} :
      (reg_addr == tc_pkg::A_EVCTRL) ? {18'h00000, mceo_r, 3'h0, wrap_event_enable_r, 6'h00, input_event_action_r} :
      (reg_addr == tc_pkg::A_FLAGS) ? flags_v :
      (reg_addr == tc_pkg::A_STATUS) ? stat_v :
      (reg_addr == tc_pkg::A_COUNT) ? count_r :
      (reg_addr == tc_pkg::A_PER) ? {24'h000000, per_r} :
      (reg_addr == tc_pkg::A_CC0) ? cc_r[0] :
      (reg_addr == tc_pkg::A_CC1) ? cc_r[1] :
      (reg_addr == tc_pkg::A_DEBUG) ? {31'h00000000, debug_r} : tc_pkg::ZERO32;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_r <= tc_pkg::ZERO32;
      end else begin
         rdata_r <= reg_rd ? rd_mux : tc_pkg::ZERO32;
      end
   end

   assign reg_rdata = rdata_r;
   assign wrap_event = wrap_ev_r;
   assign match_event = mev_r;
   assign waveform_output = pin_r;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   wire calm;
   assign calm = !reg_wr && !retrig && !start_ev;

   sequence s_stop_req;
      stop_cmd ##0 running;
   endsequence
   sequence s_frozen;
      !running && (wv_r == 2'h0);
   endsequence

   a_soft_reset_off: assert property (soft_reset_bit |=> !enable_r && !running && count_r == tc_pkg::ZERO32)
      else $error("soft reset left timer active");
   a_locked_mode: assert property (enable_r && wr_control_a && !soft_reset_bit |=> $stable(mode_r))
      else $error("locked mode changed while enabled");
   a_enable_loads: assert property (en_rise |=> mode_r == $past(reg_wdata[tc_pkg::B_MODE +: 2]))
      else $error("enabling write did not load mode");
   a_dir_set_clear: assert property (wr_bset && reg_wdata[tc_pkg::B_DIR] |=> dir_r ##1 (!wr_bclr || dir_r))
      else $error("direction set not taken");
   a_up_wrap_zero: assert property (wrap_go && !dir_r && calm |=> count_r == tc_pkg::ZERO32 && wrap_flag_r)
      else $error("up wrap did not reach zero with flag");
   a_down_reload: assert property (wrap_go && dir_r && calm |=> count_r == $past(top_val))
      else $error("down wrap did not reload top");
   a_single_stop: assert property (wrap_go && single_r && calm |=> !running)
      else $error("single run kept counting");
   a_stop_freeze: assert property (s_stop_req |=> s_frozen ##0 count_r == $past(count_r))
      else $error("stop did not freeze counter");
   a_start_waits: assert property (en_rise && input_event_action_r == tc_pkg::ev_start |=> !running)
      else $error("start action began without event");
   a_event_count: assert property (ev_cnt && running && event_in && !dir_r && !at_limit && calm
                                   |=> count_r == (($past(count_r) + 32'h00000001) & max_val))
      else $error("event did not step counter");
   a_match_flag: assert property (match_set[0] |=> mflag_r[0] ##0 (mev_r[0] == mceo_r[0]))
      else $error("match flag or event missing");
   a_follower_role: assert property (follower && reg_rd && reg_addr == tc_pkg::A_STATUS
                                     |=> reg_rdata[tc_pkg::B_FOLLOW])
      else $error("follower role not reported");
endmodule // tc_timer_counter_core
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the timer counter core
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk, rst, reg_wr, reg_rd, fire, event_in, wrap_event, pair_m;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val, held;
   logic [1:0]  match_event, waveform_output;
   int          n_fail, n_checks, seed, wrap_seen, k, m_cnt, m_top, m_dir, m_wraps;

   // Odd instance so the pairing input can be exercised at the end of the run
   tc_timer_counter_core #(.ODD_INSTANCE(1'b1)) i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
      .pair_master_32(pair_m),
      .wrap_event(wrap_event), .match_event(match_event), .waveform_output(waveform_output));
   tc_event_partner i_partner (.sys_clk(sys_clk), .rst(rst), .fire(fire), .wrap_event(wrap_event),
      .event_in(event_in), .wrap_seen(wrap_seen));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   // Reference count: up wraps top to zero, down reloads top
   task automatic pulse_events(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         fire <= 1'b1;
         @(posedge sys_clk);
         fire <= 1'b0;
         if (m_dir == 0) begin
            if (m_cnt == m_top) begin
               m_cnt = 0;
               m_wraps++;
            end else m_cnt++;
         end else begin
            if (m_cnt == 0) begin
               m_cnt = m_top;
               m_wraps++;
            end else m_cnt--;
         end
      end
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic close_out();
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #100us;
      n_fail++;
      close_out();
   end

   initial begin
      {rst, reg_wr, reg_rd, fire, pair_m, reg_addr, reg_wdata} = '0;
      rst = 1'b1;
      seed = 55861;
      {n_fail, n_checks, m_cnt, m_dir, m_wraps} = '0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd(tc_pkg::A_CONTROL_A);
      `CHK(rd_val, 32'h00000000)
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[4:3], 2'h1)
      rd(tc_pkg::A_PER);
      `CHK(rd_val, 32'h000000FF)
      rd(8'h14);
      `CHK(rd_val, 32'h00000000)
      // Counted events with the slowest prescaler still step once each
      wr(tc_pkg::A_EVCTRL, 32'h00000102);
      wr(tc_pkg::A_CONTROL_A, 32'h00000702);
      m_top = 32'hFFFF;
      k = 1 + ({$random(seed)} % 6);
      pulse_events(k);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'(m_cnt))
      wr(tc_pkg::A_BSET, 32'h00000001);
      m_dir = 1;
      pulse_events(k + 2);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'(m_cnt))
      rd(tc_pkg::A_FLAGS);
      `CHK(rd_val[0], 1'b1)
      `CHK(wrap_seen, m_wraps)
      // Locked fields while running, then on enable clear and set
      wr(tc_pkg::A_CONTROL_A, 32'h00000006);
      wr(tc_pkg::A_EVCTRL, 32'h00000100);
      rd(tc_pkg::A_CONTROL_A);
      `CHK(rd_val, 32'h00000702)
      rd(tc_pkg::A_EVCTRL);
      `CHK(rd_val, 32'h00000102)
      wr(tc_pkg::A_CONTROL_A, 32'h00000004);
      rd(tc_pkg::A_CONTROL_A);
      `CHK(rd_val, 32'h00000700)
      wr(tc_pkg::A_CONTROL_A, 32'h00000006);
      rd(tc_pkg::A_CONTROL_A);
      `CHK(rd_val, 32'h00000006)
      // 8-bit wrap at a small top limit with a random compare value
      m_top = 3;
      m_cnt = 0;
      m_dir = 0;
      wr(tc_pkg::A_PER, 32'h00000003);
      wr(tc_pkg::A_COUNT, 32'h00000000);
      wr(tc_pkg::A_BCLR, 32'h00000001);
      wr(tc_pkg::A_CC0, 32'(1 + ({$random(seed)} % 2)));
      wr(tc_pkg::A_FLAGS, 32'h00000031);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'h00000000)
      pulse_events(5);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'(m_cnt))
      rd(tc_pkg::A_FLAGS);
      `CHK(rd_val[4:0], 5'h11)
      // Free running, then stop freezes the count
      wr(tc_pkg::A_CONTROL_A, 32'h00000000);
      wr(tc_pkg::A_EVCTRL, 32'h00000000);
      wr(tc_pkg::A_CONTROL_A, 32'h00000002);
      repeat (20) @(posedge sys_clk);
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[3], 1'b0)
      wr(tc_pkg::A_BSET, 32'h00000080);
      rd(tc_pkg::A_COUNT);
      held = rd_val;
      repeat (10) @(posedge sys_clk);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, held)
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[3], 1'b1)
      `CHK(waveform_output, 2'h0)
      wr(tc_pkg::A_CONTROL_C, 32'h00000003);
      rd(tc_pkg::A_CONTROL_C);
      `CHK(rd_val[1:0], 2'h3)
      `CHK(waveform_output, 2'h3)
      wr(tc_pkg::A_BSET, 32'h00000040);
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[3], 1'b0)
      // Disabled before the soft reset; debug hold survives it
      wr(tc_pkg::A_DEBUG, 32'h00000001);
      wr(tc_pkg::A_CONTROL_A, 32'h00000000);
      wr(tc_pkg::A_CONTROL_A, 32'h00000001);
      rd(tc_pkg::A_DEBUG);
      `CHK(rd_val, 32'h00000001)
      rd(tc_pkg::A_PER);
      `CHK(rd_val, 32'h000000FF)
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'h00000000)
      // Start action: enable waits for the first event
      wr(tc_pkg::A_EVCTRL, 32'h00000003);
      wr(tc_pkg::A_CONTROL_A, 32'h00000002);
      repeat (10) @(posedge sys_clk);
      rd(tc_pkg::A_COUNT);
      `CHK(rd_val, 32'h00000000)
      pulse_events(1);
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[3], 1'b0)
      // Neighbour goes 32-bit: role shows, own writes no longer land
      pair_m <= 1'b1;
      rd(tc_pkg::A_STATUS);
      `CHK(rd_val[4], 1'b1)
      wr(tc_pkg::A_PER, 32'h00000055);
      rd(tc_pkg::A_PER);
      `CHK(rd_val, 32'h000000FF)
      close_out();
   end
endmodule // tb
`undef CHK
`default_nettype wire

// File: testbench/tc_event_partner.sv
// Event source and wrap-event observer on the far side of the timer core
`default_nettype none
module tc_event_partner (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic fire,
   input  wire logic wrap_event,
   output var logic  event_in,
   output var int    wrap_seen
);
   timeunit 1ns;
   timeprecision 100ps;
   // Registered so each request becomes exactly one event pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         event_in  <= 1'b0;
         wrap_seen <= 0;
      end else begin
         event_in <= fire;
         if (wrap_event === 1'b1) begin
            wrap_seen <= wrap_seen + 1;
         end
      end
   end
endmodule // tc_event_partner
`default_nettype wire
